/* File: design/acq_seq_pkg.sv */
// Package holding constants and types of the acquisition sequencer
package acq_seq_pkg;
    localparam int CLK_PERIOD_NS = 10;
    typedef enum logic [2:0] {
        SRC_NOT_READOUT,
        SRC_SHUTTER,
        SRC_BUSY,
        SRC_LOW,
        SRC_HIGH
    } status_src_t;
    typedef enum logic [1:0] {
        KIN_FREE_RUN,
        KIN_SINGLE,
        KIN_MULTI
    } kin_mode_t;
    typedef enum logic [1:0] {
        SHUT_NORMAL,
        SHUT_OPEN,
        SHUT_CLOSED
    } shutter_mode_t;
    localparam logic [15:0] ONE_16  = 16'h0001;
    localparam logic [15:0] ZERO_16 = 16'h0000;
endpackage

/* File: design/sync_edge_detect.sv */
// Two-stage synchroniser and selectable edge detector for the sync input
module sync_edge_detect (
    input  wire logic i_mclk,    // Clock
    input  wire logic i_reset,   // Synchronous reset
    input  wire logic i_sync,    // Raw sync input
    input  wire logic i_pos,     // 1 rising edge, 0 falling edge
    output logic      o_edge,    // One-cycle pulse on selected edge
    output logic      o_active   // Synchronised level at its active sense
);
    logic meta;
    logic sync_q;
    logic prev_q;
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            meta   <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta   <= i_sync;
            sync_q <= meta;
            prev_q <= sync_q;
        end
    end
    assign o_edge   = i_pos ? (sync_q & ~prev_q) : (~sync_q & prev_q);
    assign o_active = i_pos ? sync_q : ~sync_q;
endmodule

/* File: design/acq_sequencer.sv */
// Acquisition sequencer: start/stop handling, kinetics bursts and status output
module acq_sequencer
    import acq_seq_pkg::*;
#(
    parameter int ROW_W         = 16,   // Width of row counters
    parameter int SENSOR_ROWS   = 6,    // Rows perpendicular to the shift register
    parameter int SHIFT_NS      = 1600, // Vertical shift time per row
    parameter int CLEAN_CYCLES  = 4,    // Cleaning passes before first exposure
    parameter int READOUT_CYCLES = 64,  // Clock cycles for a normal-speed readout
    parameter int COMP_CYCLES   = 8     // Shutter compensation cycles
) (
    input  wire logic          i_mclk,        // Clock, 100 MHz
    input  wire logic          i_reset,       // Synchronous reset, active high
    input  wire logic          i_start,       // Start command pulse
    input  wire logic          i_stop,        // Stop command pulse
    input  wire logic          i_per_frame,   // 1 per-frame mode, 0 per-sequence
    input  wire logic          i_kinetics,    // 1 kinetics readout
    input  wire kin_mode_t     i_kin_mode,    // Kinetics timing mode
    input  wire shutter_mode_t i_shut_mode,   // Shutter setting
    input  wire logic          i_trig_pos,    // Trigger edge polarity, 1 rising
    input  wire logic          i_ext_sync,    // External sync input
    input  wire status_src_t   i_status_src,  // Status output source
    input  wire logic [ROW_W-1:0] i_win_rows, // Subframe height in rows
    input  wire logic [15:0]   i_exp_cycles,  // Exposure time in cycles
    input  wire logic [15:0]   i_frames,      // Frames per sequence, 0 free run
    output logic               o_status,      // Selected status output
    output logic               o_shutter,     // Shutter drive
    output logic               o_readout,     // Readout in progress
    output logic               o_busy_n,      // Low from end of cleaning to end
    output logic [15:0]        o_frame_count  // Frames taken this sequence
);
    localparam int SHIFT_CYC_RAW = SHIFT_NS / CLK_PERIOD_NS;
    localparam int SHIFT_CYCLES  = (SHIFT_CYC_RAW < 1) ? 1 : SHIFT_CYC_RAW;
    localparam logic [15:0] SHIFT_LAST = 16'(SHIFT_CYCLES - 1);
    localparam logic [15:0] CLEAN_LAST = 16'(CLEAN_CYCLES - 1);
    localparam logic [15:0] READ_LAST  = 16'(READOUT_CYCLES - 1);
    localparam logic [15:0] COMP_LAST  = 16'(COMP_CYCLES - 1);

    initial begin
        if (ROW_W < 2 || ROW_W > 16 || SENSOR_ROWS < 1 || CLEAN_CYCLES < 1
            || READOUT_CYCLES < 1 || COMP_CYCLES < 1 || SENSOR_ROWS >= (1 << ROW_W))
            $error("acq_sequencer: parameter out of range");
    end

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_CLEAN,
        ST_ARMED,
        ST_EXPOSE,
        ST_SHIFT,
        ST_WAIT_TRIG,
        ST_COMP,
        ST_READ,
        ST_HOLD
    } state_t;

    state_t      state;
    state_t      next_state;
    logic [15:0] timer;
    logic [15:0] next_timer;
    logic [ROW_W-1:0] row_cnt;
    logic [ROW_W-1:0] next_row_cnt;
    logic [ROW_W-1:0] sub_cnt;
    logic [ROW_W-1:0] next_sub_cnt;
    logic [15:0] frame_cnt;
    logic [15:0] next_frame_cnt;
    logic        running;
    logic        next_running;
    logic        busy_n;
    logic        next_busy_n;

    wire trig_edge;
    wire trig_active;

    sync_edge_detect u_sync (
        .i_mclk   (i_mclk),
        .i_reset  (i_reset),
        .i_sync   (i_ext_sync),
        .i_pos    (i_trig_pos),
        .o_edge   (trig_edge),
        .o_active (trig_active)
    );

    // Subframe total is rows over height; zero height is treated as one
    function automatic logic [ROW_W-1:0] subframe_total(input logic [ROW_W-1:0] h);
        logic [ROW_W-1:0] hh;
        hh = (h == '0) ? ROW_W'(1) : h;
        return ROW_W'(SENSOR_ROWS) / hh;
    endfunction

    wire [ROW_W-1:0] sub_total  = subframe_total(i_win_rows);
    wire [ROW_W-1:0] win_h      = (i_win_rows == '0) ? ROW_W'(1) : i_win_rows;
    wire             kin_free   = i_kinetics && (i_kin_mode == KIN_FREE_RUN);
    wire             kin_multi  = i_kinetics && (i_kin_mode == KIN_MULTI);
    wire             needs_trig = i_kinetics && (i_kin_mode != KIN_FREE_RUN);
    wire             timer_done = (timer == ZERO_16);
    wire             shift_done = (timer == SHIFT_LAST);
    wire             row_last   = (row_cnt == win_h - ROW_W'(1));
    wire             sub_last   = (sub_cnt == sub_total - ROW_W'(1));
    wire             seq_last   = (i_frames != ZERO_16) && (frame_cnt + ONE_16 >= i_frames);
    wire             exp_end    = (timer + ONE_16 >= i_exp_cycles);
    // Preopen shutter holds open while waiting; multi-trigger kinetics opens at run
    wire             shut_open_wait = kin_multi || i_shut_mode == SHUT_OPEN;
    wire             shut_allowed   = i_shut_mode != SHUT_CLOSED;
    wire             shutter_now = shut_allowed && (state == ST_EXPOSE || state == ST_SHIFT
                                   || (state == ST_WAIT_TRIG && shut_open_wait)
                                   || (state == ST_ARMED && shut_open_wait));
    wire             readout_now = (state == ST_READ);

    always_comb begin
        next_state     = state;
        next_timer     = timer + ONE_16;
        next_row_cnt   = row_cnt;
        next_sub_cnt   = sub_cnt;
        next_frame_cnt = frame_cnt;
        next_running   = running;
        next_busy_n    = busy_n;
        if (i_stop) begin
            next_running = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                next_timer = ZERO_16;
                if (i_start) begin
                    next_state     = ST_CLEAN;
                    next_running   = 1'b1;
                    next_frame_cnt = ZERO_16;
                    next_busy_n    = 1'b1;
                end
            end
            ST_CLEAN: begin
                if (timer == CLEAN_LAST) begin
                    next_timer  = ZERO_16;
                    next_state  = ST_ARMED;
                    next_busy_n = 1'b0;
                end
            end
            ST_ARMED: begin
                next_timer   = ZERO_16;
                next_row_cnt = '0;
                next_sub_cnt = '0;
                if (!running) begin
                    next_state  = ST_IDLE;
                    next_busy_n = 1'b1;
                end else if (!needs_trig || trig_edge || trig_active) begin
                    // Level still active after readout counts again
                    // Multi-trigger series: the first pulse starts the first subframe
                    next_state = ST_EXPOSE;
                end
            end
            ST_EXPOSE: begin
                if (exp_end) begin
                    next_timer = ZERO_16;
                    next_state = i_kinetics ? ST_SHIFT : ST_COMP;
                end
            end
            ST_SHIFT: begin
                if (shift_done) begin
                    next_timer   = ZERO_16;
                    next_row_cnt = row_cnt + ROW_W'(1);
                    if (row_last) begin
                        next_row_cnt = '0;
                        next_sub_cnt = sub_cnt + ROW_W'(1);
                        if (sub_last) begin
                            next_state = ST_COMP;
                        end else if (kin_multi) begin
                            next_state = ST_WAIT_TRIG;
                        end else begin
                            next_state = ST_EXPOSE;
                        end
                    end
                end
            end
            ST_WAIT_TRIG: begin
                next_timer = ZERO_16;
                if (trig_edge) begin
                    next_state = ST_EXPOSE;
                end
            end
            ST_COMP: begin
                if (timer == COMP_LAST) begin
                    next_timer = ZERO_16;
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (timer == READ_LAST) begin
                    next_timer     = ZERO_16;
                    next_frame_cnt = frame_cnt + ONE_16;
                    if (seq_last || !running) begin
                        next_state  = ST_IDLE;
                        next_busy_n = 1'b1;
                    end else if (i_per_frame) begin
                        next_state = ST_HOLD;
                    end else begin
                        next_state = ST_ARMED;
                    end
                end
            end
            ST_HOLD: begin
                next_timer = ZERO_16;
                if (!running) begin
                    next_state  = ST_IDLE;
                    next_busy_n = 1'b1;
                end
                if (i_start) begin
                    next_state   = ST_ARMED;
                    next_running = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state     <= ST_IDLE;
            timer     <= ZERO_16;
            row_cnt   <= '0;
            sub_cnt   <= '0;
            frame_cnt <= ZERO_16;
            running   <= 1'b0;
            busy_n    <= 1'b1;
        end else begin
            state     <= next_state;
            timer     <= next_timer;
            row_cnt   <= next_row_cnt;
            sub_cnt   <= next_sub_cnt;
            frame_cnt <= next_frame_cnt;
            running   <= next_running;
            busy_n    <= next_busy_n;
        end
    end

    // Status source select; registered so the pin never glitches
    wire status_sel = (i_status_src == SRC_NOT_READOUT) ? ~readout_now :
                      (i_status_src == SRC_SHUTTER)     ? shutter_now :
                      (i_status_src == SRC_BUSY)        ? next_busy_n :
                      (i_status_src == SRC_HIGH);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_status      <= 1'b1;
            o_shutter     <= 1'b0;
            o_readout     <= 1'b0;
            o_busy_n      <= 1'b1;
            o_frame_count <= ZERO_16;
        end else begin
            o_status      <= status_sel;
            o_shutter     <= shutter_now;
            o_readout     <= readout_now;
            o_busy_n      <= next_busy_n;
            o_frame_count <= next_frame_cnt;
        end
    end

    property p_readout_status;
        @(posedge i_mclk) disable iff (i_reset)
        (i_status_src == SRC_NOT_READOUT && $stable(i_status_src)) |=> (o_status == ~o_readout);
    endproperty
    a_readout_status: assert property (p_readout_status) else $error("status not inverse readout");

    property p_shutter_status;
        @(posedge i_mclk) disable iff (i_reset)
        (i_status_src == SRC_SHUTTER) |=> (o_status == o_shutter);
    endproperty
    a_shutter_status: assert property (p_shutter_status) else $error("status not shutter");

    property p_low_const;
        @(posedge i_mclk) disable iff (i_reset)
        (i_status_src == SRC_LOW) |=> !o_status;
    endproperty
    a_low_const: assert property (p_low_const) else $error("constant low violated");

    property p_high_const;
        @(posedge i_mclk) disable iff (i_reset)
        (i_status_src == SRC_HIGH) |=> o_status;
    endproperty
    a_high_const: assert property (p_high_const) else $error("constant high violated");

    property p_busy_low_after_clean;
        @(posedge i_mclk) disable iff (i_reset)
        (state == ST_CLEAN && timer == CLEAN_LAST) |=> (state == ST_ARMED) ##0 !busy_n;
    endproperty
    a_busy_low_after_clean: assert property (p_busy_low_after_clean) else $error("busy not low");

    property p_hold_per_frame;
        @(posedge i_mclk) disable iff (i_reset)
        (state == ST_HOLD && !i_start) |=> (state == ST_HOLD || state == ST_IDLE);
    endproperty
    a_hold_per_frame: assert property (p_hold_per_frame) else $error("frame taken without start");

    property p_multi_waits;
        @(posedge i_mclk) disable iff (i_reset)
        (state == ST_WAIT_TRIG && !trig_edge) |=> (state == ST_WAIT_TRIG);
    endproperty
    a_multi_waits: assert property (p_multi_waits) else $error("advanced without trigger");

    property p_no_readout_shutter;
        @(posedge i_mclk) disable iff (i_reset)
        o_readout |-> !o_shutter;
    endproperty
    a_no_readout_shutter: assert property (p_no_readout_shutter) else $error("shutter open in readout");

    property p_closed_shutter;
        @(posedge i_mclk) disable iff (i_reset)
        (i_shut_mode == SHUT_CLOSED) |=> !o_shutter;
    endproperty
    a_closed_shutter: assert property (p_closed_shutter) else $error("shutter opened while disabled");

    sequence s_last_shift;
        state == ST_SHIFT && shift_done && row_last && sub_last;
    endsequence

    sequence s_comp_start;
        (state == ST_COMP && timer == ZERO_16) ##1 !o_shutter;
    endsequence

    property p_series_end;
        @(posedge i_mclk) disable iff (i_reset)
        s_last_shift |=> s_comp_start;
    endproperty
    a_series_end: assert property (p_series_end) else $error("series not closed at last subframe");

    sequence s_last_read;
        state == ST_READ && timer == READ_LAST && seq_last;
    endsequence

    property p_busy_returns;
        @(posedge i_mclk) disable iff (i_reset)
        s_last_read |=> (o_busy_n && state == ST_IDLE);
    endproperty
    a_busy_returns: assert property (p_busy_returns) else $error("busy not released after last frame");

    // Per-sequence runs must re-arm by themselves with busy still asserted
    property p_seq_continues;
        @(posedge i_mclk) disable iff (i_reset)
        (state == ST_READ && timer == READ_LAST && !seq_last && running && !i_per_frame)
        |=> (state == ST_ARMED && !o_busy_n);
    endproperty
    a_seq_continues: assert property (p_seq_continues) else $error("sequence did not continue");
endmodule

/* File: testbench/host_trig_model.sv */
// Host command source and external sync equipment facing the sequencer
module host_trig_model (
    input  wire logic i_mclk,   // Clock, changes made at falling edge
    input  wire logic i_pos,    // Configured active edge, 1 rising
    output logic      o_start,  // Start command pulse
    output logic      o_stop,   // Stop command pulse
    output logic      o_sync    // External sync line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic active = 1'b0;
    // Rests at the inactive level, so a pulse opens with the configured edge
    assign o_sync = ~(active ^ i_pos);
    initial begin
        o_start = 1'b0;
        o_stop  = 1'b0;
    end
    task automatic pulse_start();
        @(negedge i_mclk);
        o_start = 1'b1;
        @(negedge i_mclk);
        o_start = 1'b0;
    endtask
    task automatic pulse_stop();
        @(negedge i_mclk);
        o_stop = 1'b1;
        @(negedge i_mclk);
        o_stop = 1'b0;
    endtask
    // Both phases last several cycles, or the synchroniser could miss the edge
    task automatic pulse_trig(input int width);
        @(negedge i_mclk);
        active = 1'b1;
        repeat (width) @(negedge i_mclk);
        active = 1'b0;
        repeat (4) @(negedge i_mclk);
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the acquisition sequencer
module tb_top
    import acq_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ROWS = 6;
    localparam int CLEAN = 4;
    localparam int READ = 64;
    localparam int COMP = 8;
    // Short row shift keeps kinetics runs brief
    localparam int SHIFT_CYC = 200 / CLK_PERIOD_NS;
    logic          i_mclk = 1'b0;
    logic          i_reset = 1'b1;
    logic          i_per_frame = 1'b0;
    logic          i_kinetics = 1'b0;
    logic          i_trig_pos = 1'b1;
    kin_mode_t     i_kin_mode = KIN_FREE_RUN;
    shutter_mode_t i_shut_mode = SHUT_NORMAL;
    status_src_t   i_status_src = SRC_NOT_READOUT;
    status_src_t   src_q;
    logic [15:0]   i_win_rows = 16'h0002;
    logic [15:0]   i_exp_cycles = 16'h0004;
    logic [15:0]   i_frames = 16'h0003;
    logic [15:0]   o_frame_count;
    logic          i_start, i_stop, i_ext_sync, o_status, o_shutter, o_readout, o_busy_n;
    logic          ref_v, rd_q, rst_q;
    logic [1:0]    ref_h;
    int            n_errors = 0;
    int            tests_run = 0;
    int            n_reads = 0;
    int            seed = 13513;

    always #(CLK_PERIOD_NS / 2) i_mclk = ~i_mclk;

    host_trig_model host (.i_mclk(i_mclk), .i_pos(i_trig_pos), .o_start(i_start),
        .o_stop(i_stop), .o_sync(i_ext_sync));

    acq_sequencer #(.SENSOR_ROWS(ROWS), .SHIFT_NS(200), .CLEAN_CYCLES(CLEAN),
        .READOUT_CYCLES(READ), .COMP_CYCLES(COMP)) dut (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_start(i_start), .i_stop(i_stop),
        .i_per_frame(i_per_frame), .i_kinetics(i_kinetics), .i_kin_mode(i_kin_mode),
        .i_shut_mode(i_shut_mode), .i_trig_pos(i_trig_pos), .i_ext_sync(i_ext_sync),
        .i_status_src(i_status_src), .i_win_rows(i_win_rows),
        .i_exp_cycles(i_exp_cycles), .i_frames(i_frames), .o_status(o_status),
        .o_shutter(o_shutter), .o_readout(o_readout), .o_busy_n(o_busy_n),
        .o_frame_count(o_frame_count));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp_v, input logic [15:0] got);
        tests_run++;
        if (got !== exp_v) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp_v, got);
        end
    endtask

    // Selector: 0 readout, 1 busy_n, 2 shutter, 3 frame count
    task automatic wait_for(input int which, input logic [15:0] val, input int bound,
                            output int n);
        logic [15:0] s;
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
            s = (which == 0) ? {15'h0000, o_readout} : (which == 1) ? {15'h0000, o_busy_n} :
                (which == 2) ? {15'h0000, o_shutter} : o_frame_count;
        end while (s !== val && n < bound);
        if (s !== val) begin
            n_errors++;
            $display("mismatch wait %0d expected %0h seen %0h", which, val, s);
            finish_test();
        end
    endtask

    task automatic do_reset();
        @(negedge i_mclk);
        i_reset = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_reset = 1'b0;
    endtask

    function automatic logic [15:0] rnd(input int m);
        return 16'($unsigned($random(seed)) % m) + 16'h0001;
    endfunction

    // Status must copy its source; compared only once source and selection have settled
    assign ref_v = (i_status_src == SRC_SHUTTER) ? o_shutter :
                   (i_status_src == SRC_BUSY) ? o_busy_n : ~o_readout;
    always @(posedge i_mclk) begin
        ref_h <= {ref_h[0], ref_v};
        src_q <= i_status_src;
        rst_q <= i_reset;
        rd_q <= o_readout;
        if (o_readout && !rd_q)
            n_reads <= n_reads + 1;
    end
    always @(negedge i_mclk) begin
        // Skip the edge of reset release: outputs still hold their reset levels there
        if (!i_reset && !rst_q && src_q == i_status_src && ref_h == {2{ref_v}} &&
            i_status_src inside {SRC_NOT_READOUT, SRC_SHUTTER, SRC_BUSY})
            check("status", {15'h0000, ref_v}, {15'h0000, o_status});
    end

    initial begin
        int n, len, r0, exp_len;
        do_reset();
        check("status", 16'h0001, {15'h0000, o_status});
        check("busy_n", 16'h0001, {15'h0000, o_busy_n});
        check("count", 16'h0000, o_frame_count);
        for (int k = 0; k < 2; k++) begin
            i_status_src = k[0] ? SRC_HIGH : SRC_LOW;
            repeat (3) @(negedge i_mclk);
            check("const", 16'(k), {15'h0000, o_status});
        end
        // Per-sequence run of three frames
        i_status_src = SRC_BUSY;
        i_exp_cycles = rnd(16);
        r0 = n_reads;
        host.pulse_start();
        check("busy_n", 16'h0001, {15'h0000, o_busy_n});
        wait_for(1, 16'h0000, 50, n);
        check("busy delay", 16'(CLEAN), 16'(n));
        wait_for(1, 16'h0001, 3000, n);
        check("frames", 16'h0003, o_frame_count);
        check("readouts", 16'h0003, 16'(n_reads - r0));
        // Per-frame: one frame per start
        do_reset();
        i_status_src = SRC_SHUTTER;
        i_per_frame = 1'b1;
        r0 = n_reads;
        host.pulse_start();
        wait_for(3, 16'h0001, 1000, n);
        repeat (200) @(negedge i_mclk);
        check("halt", 16'h0001, 16'(n_reads - r0));
        host.pulse_start();
        wait_for(3, 16'h0002, 1000, n);
        host.pulse_stop();
        // Free run until stop, shutter held closed
        do_reset();
        i_status_src = SRC_NOT_READOUT;
        i_per_frame = 1'b0;
        i_frames = 16'h0000;
        i_shut_mode = SHUT_CLOSED;
        host.pulse_start();
        wait_for(3, 16'h0004, 3000, n);
        check("busy_n run", 16'h0000, {15'h0000, o_busy_n});
        check("shut closed", 16'h0000, {15'h0000, o_shutter});
        host.pulse_stop();
        wait_for(1, 16'h0001, 400, n);
        // Kinetics free run over every window height that divides the sensor
        i_shut_mode = SHUT_NORMAL;
        i_kinetics = 1'b1;
        i_per_frame = 1'b1;
        i_frames = 16'h0001;
        for (int w = 1; w <= ROWS; w++) begin
            if (ROWS % w != 0)
                continue;
            do_reset();
            i_win_rows = 16'(w);
            i_exp_cycles = rnd(16);
            exp_len = (ROWS / w) * (int'(i_exp_cycles) + w * SHIFT_CYC);
            host.pulse_start();
            wait_for(2, 16'h0001, 100, n);
            wait_for(2, 16'h0000, 5000, len);
            check("shutter span", 16'h0001, 16'(len >= exp_len - 2 && len <= exp_len + COMP + 2));
            wait_for(0, 16'h0001, 100, n);
            wait_for(0, 16'h0000, 200, len);
            check("readout len", 16'(READ), 16'(len));
            wait_for(3, 16'h0001, 50, n);
        end
        // Triggered kinetics, both modes and both edge polarities
        i_status_src = SRC_SHUTTER;
        i_win_rows = 16'h0002;
        for (int t = 0; t < 4; t++) begin
            i_kin_mode = t[1] ? KIN_MULTI : KIN_SINGLE;
            i_trig_pos = t[0];
            i_shut_mode = (t == 1) ? SHUT_OPEN : SHUT_NORMAL;
            do_reset();
            r0 = n_reads;
            host.pulse_start();
            repeat (40) @(negedge i_mclk);
            check("preopen", 16'(t[1] || t == 1), {15'h0000, o_shutter});
            for (int p = 1; p < (t[1] ? ROWS / 2 : 1); p++) begin
                host.pulse_trig(3);
                repeat (80) @(negedge i_mclk);
            end
            check("waiting", 16'h0000, 16'(n_reads - r0));
            host.pulse_trig(3);
            wait_for(0, 16'h0001, 400, n);
            wait_for(0, 16'h0000, 100, n);
            repeat (150) @(negedge i_mclk);
            check("one series", 16'h0001, 16'(n_reads - r0));
        end
        finish_test();
    end
endmodule
